// ===== verilog/ecc_pkg.sv
// ecc_pkg: register map, field positions and modes of the encoder
// capture/compare block; assumes a 32-bit AHB-Lite register window.
package ecc_pkg;
	localparam int ECC_POS_W = 24;
	// printed offsets are not all multiples of four: they are indices
	localparam logic [15:0] ECC_IDX_CTRL_STATUS = 16'hc000;
	localparam logic [15:0] ECC_IDX_CAP_CMP     = 16'hc003;
	localparam logic [15:0] ECC_IDX_TRIG_CFG    = 16'hc004;
	localparam int ECC_ADDR_W = 18;
	// control/status word field positions
	localparam int ECC_B_LATCH_SEL  = 11;
	localparam int ECC_B_OUT_EN     = 12;
	localparam int ECC_B_OUT_INV    = 13;
	localparam int ECC_B_SW_TRIG    = 14;
	localparam int ECC_B_CMP_EQ     = 16;
	localparam int ECC_B_CAPTURED   = 17;
	// trigger configuration word fields
	localparam int ECC_F_COMB_LSB   = 0;
	localparam int ECC_F_COMB_W     = 2;
	localparam int ECC_F_FLAG_LSB   = 4;
	localparam int ECC_F_FLAG_W     = 2;
	localparam logic [23:0] ECC_CTRL_RST = 24'h00_0000;
	localparam logic [3:0]  ECC_TRIG_RST = 4'h0;
	localparam logic [23:0] ECC_CMP_RST  = 24'h00_0000;
	localparam logic [1:0] ECC_COMB_SW    = 2'h0;
	localparam logic [1:0] ECC_COMB_INDEX = 2'h1;
	localparam logic [1:0] ECC_COMB_FLAG  = 2'h2;
	localparam logic [1:0] ECC_COMB_BOTH  = 2'h3;
endpackage

// ===== verilog/ecc_sync.sv
// ecc_sync: two-flop synchroniser for a bus of pin levels.
// assumes the destination clock is the block clock.
`timescale 1ns/100ps
module ecc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= d_i;
			sync_q <= meta_q;
		end
	end

	assign q_o = sync_q;
endmodule

// ===== verilog/ecc_trigger.sv
// ecc_trigger: capture-event selection from the index channel and one
// of four input flags; assumes its inputs are already synchronised.
`timescale 1ns/100ps
module ecc_trigger
	import ecc_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       index_i,
	input  wire logic [3:0] flags_i,
	input  wire logic [1:0] comb_i,
	input  wire logic [1:0] flag_sel_i,
	input  wire logic       sw_trig_i,
	output logic            fire_o
);
	logic index_prev_q;
	logic index_prev_d;
	logic flag_prev_q;
	logic flag_prev_d;
	logic flag_now;
	logic index_rise;
	logic flag_rise;

	always_comb begin
		flag_now     = flags_i[flag_sel_i];
		index_prev_d = index_i;
		flag_prev_d  = flag_now;
		index_rise   = index_i & ~index_prev_q;
		flag_rise    = flag_now & ~flag_prev_q;
		fire_o       = 1'b0;
		unique case (comb_i)
			ECC_COMB_SW:    fire_o = sw_trig_i;
			ECC_COMB_INDEX: fire_o = index_rise;
			ECC_COMB_FLAG:  fire_o = flag_rise;
			ECC_COMB_BOTH:  fire_o = index_rise & flag_now;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			index_prev_q <= 1'b0;
			flag_prev_q  <= 1'b0;
		end else begin
			index_prev_q <= index_prev_d;
			flag_prev_q  <= flag_prev_d;
		end
	end
endmodule

// ===== verilog/ecc_top.sv
// ecc_top: encoder position capture and compare with AHB-Lite registers.
// assumes a count-update strobe and count from the counter on mclk_i;
// index and flag pins are asynchronous and synchronised here.
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
module ecc_top
	import ecc_pkg::*;
(
	input  wire logic                 mclk_i,
	input  wire logic                 rstn_i,
	input  wire logic                 hsel_i,
	input  wire logic [31:0]          haddr_i,
	input  wire logic [1:0]           htrans_i,
	input  wire logic                 hwrite_i,
	input  wire logic [2:0]           hsize_i,
	input  wire logic [31:0]          hwdata_i,
	input  wire logic                 hready_i,
	output logic      [31:0]          hrdata_o,
	output logic                      hreadyout_o,
	output logic                      hresp_o,
	input  wire logic [ECC_POS_W-1:0] enc_count_i,
	input  wire logic                 enc_update_i,
	input  wire logic                 index_i,
	input  wire logic [3:0]           flags_i,
	output logic                      compare_equal_pin_o,
	output logic                      compare_equal_pin_oe_n_o
);
	logic          rst_meta_q;
	logic          rst_n_q;
	logic [4:0]    pins_sync;
	logic          trig_fire;

	// address phase registers
	logic          ap_valid_q;
	logic          ap_valid_d;
	logic          ap_write_q;
	logic          ap_write_d;
	logic [15:0]   ap_idx_q;
	logic [15:0]   ap_idx_d;

	// control and configuration
	logic          latch_sel_q;
	logic          latch_sel_d;
	logic          out_en_q;
	logic          out_en_d;
	logic          out_inv_q;
	logic          out_inv_d;
	logic          sw_trig_q;
	logic          sw_trig_d;
	logic [1:0]    comb_q;
	logic [1:0]    comb_d;
	logic [1:0]    flag_sel_q;
	logic [1:0]    flag_sel_d;
	logic signed [ECC_POS_W-1:0] cmp_pos_q;
	logic signed [ECC_POS_W-1:0] cmp_pos_d;

	// capture and compare state
	logic [ECC_POS_W-1:0] cap_pos_q;
	logic [ECC_POS_W-1:0] cap_pos_d;
	logic          captured_q;
	logic          captured_d;
	logic          eq_latch_q;
	logic          eq_latch_d;
	logic          match_q;
	logic          match_d;
	logic          cmp_equal;
	logic [31:0]   rdata_q;
	logic [31:0]   rdata_d;

	logic          wr_ctrl;
	logic          wr_cmp;
	logic          wr_trig;
	logic          rd_cap;
	logic          ap_take;

	// reset released through two flops so release is glitch free
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	ecc_sync #(
		.W (5)
	) u_sync (
		.clk_i   (mclk_i),
		.rst_n_i (rst_n_q),
		.d_i     ({index_i, flags_i}),
		.q_o     (pins_sync)
	);

	ecc_trigger u_trig (
		.clk_i      (mclk_i),
		.rst_n_i    (rst_n_q),
		.index_i    (pins_sync[4]),
		.flags_i    (pins_sync[3:0]),
		.comb_i     (comb_q),
		.flag_sel_i (flag_sel_q),
		.sw_trig_i  (sw_trig_q),
		.fire_o     (trig_fire)
	);

	// bus: zero-wait slave, always OKAY
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
	assign hrdata_o    = rdata_q;

	always_comb begin
		ap_take    = hsel_i & hready_i & htrans_i[1];
		ap_valid_d = ap_take;
		ap_write_d = hwrite_i;
		ap_idx_d   = haddr_i[ECC_ADDR_W-1:2];
		wr_ctrl    = ap_valid_q & ap_write_q
			& (ap_idx_q == ECC_IDX_CTRL_STATUS);
		wr_cmp     = ap_valid_q & ap_write_q
			& (ap_idx_q == ECC_IDX_CAP_CMP);
		wr_trig    = ap_valid_q & ap_write_q
			& (ap_idx_q == ECC_IDX_TRIG_CFG);
		// read data is loaded at the address phase edge
		rd_cap     = ap_take & ~hwrite_i
			& (haddr_i[ECC_ADDR_W-1:2] == ECC_IDX_CAP_CMP);
		rdata_d    = 32'h0000_0000;
		if (ap_take && !hwrite_i) begin
			unique case (haddr_i[ECC_ADDR_W-1:2])
				ECC_IDX_CTRL_STATUS: begin
					rdata_d[ECC_B_LATCH_SEL] = latch_sel_q;
					rdata_d[ECC_B_OUT_EN]    = out_en_q;
					rdata_d[ECC_B_OUT_INV]   = out_inv_q;
					rdata_d[ECC_B_CMP_EQ]    = cmp_equal;
					rdata_d[ECC_B_CAPTURED]  = captured_q;
				end
				ECC_IDX_CAP_CMP:
					rdata_d[ECC_POS_W-1:0] = cap_pos_q;
				ECC_IDX_TRIG_CFG: begin
					rdata_d[ECC_F_COMB_LSB +: ECC_F_COMB_W] = comb_q;
					rdata_d[ECC_F_FLAG_LSB +: ECC_F_FLAG_W] = flag_sel_q;
				end
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// control registers
	always_comb begin
		latch_sel_d = latch_sel_q;
		out_en_d    = out_en_q;
		out_inv_d   = out_inv_q;
		sw_trig_d   = 1'b0;
		comb_d      = comb_q;
		flag_sel_d  = flag_sel_q;
		cmp_pos_d   = cmp_pos_q;
		if (wr_ctrl) begin
			latch_sel_d = hwdata_i[ECC_B_LATCH_SEL];
			out_en_d    = hwdata_i[ECC_B_OUT_EN];
			out_inv_d   = hwdata_i[ECC_B_OUT_INV];
			sw_trig_d   = hwdata_i[ECC_B_SW_TRIG];
		end
		if (wr_trig) begin
			comb_d     = hwdata_i[ECC_F_COMB_LSB +: ECC_F_COMB_W];
			flag_sel_d = hwdata_i[ECC_F_FLAG_LSB +: ECC_F_FLAG_W];
		end
		if (wr_cmp) begin
			cmp_pos_d = hwdata_i[ECC_POS_W-1:0];
		end
	end

	// capture: trigger is ignored while the flag stands
	always_comb begin
		cap_pos_d  = cap_pos_q;
		captured_d = captured_q;
		if (trig_fire && !captured_q) begin
			cap_pos_d  = enc_count_i;
			captured_d = 1'b1;
		end else if (rd_cap) begin
			captured_d = 1'b0;
		end
	end

	// compare: match recomputed on each count update
	always_comb begin
		match_d = match_q;
		if (enc_update_i || wr_cmp) begin
			match_d = (wr_cmp ? $signed(enc_count_i) == cmp_pos_d
				: $signed(enc_count_i) == cmp_pos_q);
		end
		eq_latch_d = eq_latch_q;
		if (!latch_sel_q) begin
			eq_latch_d = 1'b0;
		end else if (match_q) begin
			eq_latch_d = 1'b1;
		end
		cmp_equal = latch_sel_q ? (eq_latch_q | match_q) : match_q;
	end

	// open-collector style pin: released unless enabled
	assign compare_equal_pin_o      = cmp_equal ^ out_inv_q;
	assign compare_equal_pin_oe_n_o = ~out_en_q;

	always_ff @(posedge mclk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ap_valid_q  <= 1'b0;
			ap_write_q  <= 1'b0;
			ap_idx_q    <= 16'h0000;
			rdata_q     <= 32'h0000_0000;
			latch_sel_q <= ECC_CTRL_RST[ECC_B_LATCH_SEL];
			out_en_q    <= ECC_CTRL_RST[ECC_B_OUT_EN];
			out_inv_q   <= ECC_CTRL_RST[ECC_B_OUT_INV];
			sw_trig_q   <= 1'b0;
			comb_q      <= ECC_TRIG_RST[1:0];
			flag_sel_q  <= ECC_TRIG_RST[3:2];
			cmp_pos_q   <= ECC_CMP_RST;
			cap_pos_q   <= 24'h00_0000;
			captured_q  <= 1'b0;
			eq_latch_q  <= 1'b0;
			match_q     <= 1'b0;
		end else begin
			ap_valid_q  <= ap_valid_d;
			ap_write_q  <= ap_write_d;
			ap_idx_q    <= ap_idx_d;
			rdata_q     <= rdata_d;
			latch_sel_q <= latch_sel_d;
			out_en_q    <= out_en_d;
			out_inv_q   <= out_inv_d;
			sw_trig_q   <= sw_trig_d;
			comb_q      <= comb_d;
			flag_sel_q  <= flag_sel_d;
			cmp_pos_q   <= cmp_pos_d;
			cap_pos_q   <= cap_pos_d;
			captured_q  <= captured_d;
			eq_latch_q  <= eq_latch_d;
			match_q     <= match_d;
		end
	end
endmodule

// ===== tb/ecc_props.sv
// ecc_props: bus and equal-pin relations of ecc_top, seen at its ports.
// assumes one AHB-Lite master with hready_i fed from hreadyout_o.
`timescale 1ns/100ps
module ecc_props
	import ecc_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        rstn_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	input  wire logic [31:0] hrdata_o,
	input  wire logic        hreadyout_o,
	input  wire logic        hresp_o,
	input  wire logic        enc_update_i,
	input  wire logic        compare_equal_pin_o,
	input  wire logic        compare_equal_pin_oe_n_o
);
	localparam logic [31:0] A_C = {14'h0, ECC_IDX_CTRL_STATUS, 2'h0};
	localparam logic [31:0] A_P = {14'h0, ECC_IDX_CAP_CMP, 2'h0};
	localparam logic [31:0] A_T = {14'h0, ECC_IDX_TRIG_CFG, 2'h0};
	logic        rd_q;
	logic        wr_q;
	logic [31:0] a_q;
	logic [1:0]  qc_q;
	wire ap = hsel_i & hready_i & htrans_i[1];
	wire rc = rd_q & (a_q == A_C);
	wire wc = wr_q & (a_q == A_C);
	wire un = rd_q & (a_q != A_C) & (a_q != A_P) & (a_q != A_T);
	// the pin may still move two edges after a write or count update
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			a_q  <= 32'h0000_0000;
			qc_q <= 2'h0;
		end else begin
			if (hready_i) begin
				rd_q <= ap & ~hwrite_i;
				wr_q <= ap & hwrite_i;
				a_q  <= haddr_i;
			end
			if (enc_update_i | wr_q)
				qc_q <= 2'h0;
			else if (qc_q != 2'h3)
				qc_q <= qc_q + 2'h1;
		end
	end
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (!rstn_i);
	AST_READY: assert property (hreadyout_o)
		else $error("hreadyout low");
	AST_OKAY: assert property (!hresp_o)
		else $error("error response");
	AST_OE_WR: assert property (wc |=>
		compare_equal_pin_oe_n_o == !$past(hwdata_i[ECC_B_OUT_EN]))
		else $error("pin enable not loaded");
	AST_OE_HOLD: assert property ($changed(compare_equal_pin_oe_n_o) |->
		$past(wc)) else $error("pin enable moved");
	AST_RD_OE: assert property (rc && qc_q == 2'h3 |->
		compare_equal_pin_oe_n_o == !hrdata_o[ECC_B_OUT_EN])
		else $error("enable differs");
	AST_RD_PIN: assert property (rc && qc_q == 2'h3 |->
		compare_equal_pin_o == (hrdata_o[16] ^ hrdata_o[13]))
		else $error("pin differs from status");
	AST_UNMAP: assert property (un |-> hrdata_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	AST_QUIET: assert property (qc_q == 2'h3 |->
		$stable(compare_equal_pin_o)) else $error("pin moved alone");
endmodule
bind ecc_top ecc_props i_ecc_props (.*);

// ===== tb/ecc_enc_model.sv
// ecc_enc_model: quadrature counter on the far side of ecc_top.
// assumes steps are commanded by the bench on the block clock.
`timescale 1ns/100ps
module ecc_enc_model
	import ecc_pkg::*;
(
	input  wire logic                 clk_i,
	input  wire logic                 rst_n_i,
	input  wire logic                 step_i,
	input  wire logic                 down_i,
	output logic      [ECC_POS_W-1:0] count_o,
	output logic                      update_o
);
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_o  <= '0;
			update_o <= 1'b0;
		end else begin
			update_o <= step_i;
			if (step_i)
				count_o <= down_i ? count_o - 1'b1 : count_o + 1'b1;
		end
	end
endmodule

// ===== tb/tb_top.sv
// tb_top: self-checking bench for ecc_top with a counter model.
// assumes zero-wait registers; reads are judged by a queue monitor.
`timescale 1ns/100ps
module tb_top;
	import ecc_pkg::*;
	localparam logic [31:0] A_C = {14'h0, ECC_IDX_CTRL_STATUS, 2'h0};
	localparam logic [31:0] A_P = {14'h0, ECC_IDX_CAP_CMP, 2'h0};
	localparam logic [31:0] A_T = {14'h0, ECC_IDX_TRIG_CFG, 2'h0};
	logic        mclk_i = 0, rstn_i = 0, hsel = 0, hwrite = 0;
	logic        idx = 0, st = 0, dn = 0, rdp = 0, hrdy, hresp, pin, oe_n, upd;
	logic [31:0] haddr = 0, hwdata = 0, hrdata;
	logic [1:0]  htrans = 0;
	logic [3:0]  flg = 0;
	logic [23:0] cnt_w, cnt = 0, c, k;
	logic [63:0] e, q[$];
	int          failures = 0, checks = 0, cyc = 0, m, s, nn, iv;
	always #12.5 mclk_i = ~mclk_i;
	ecc_top i_ecc_top (.mclk_i, .rstn_i, .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
		.hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
		.hreadyout_o(hrdy), .hresp_o(hresp), .enc_count_i(cnt_w),
		.enc_update_i(upd), .index_i(idx), .flags_i(flg),
		.compare_equal_pin_o(pin), .compare_equal_pin_oe_n_o(oe_n));
	ecc_enc_model i_ecc_enc_model (.clk_i(mclk_i), .rst_n_i(rstn_i),
		.step_i(st), .down_i(dn), .count_o(cnt_w), .update_o(upd));
	task cmp(input logic [31:0] g, x);
		checks++;
		if (g !== x) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	task close_out;
		if (failures == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task bus(input logic w, input logic [31:0] a, d, mk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge mclk_i); while (hrdy !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		if (!w)
			q.push_back({mk, d & mk});
		do @(posedge mclk_i); while (hrdy !== 1'b1);
	endtask
	task rd(input logic [31:0] a, mk, d);
		bus(1'b0, a, d, mk);
	endtask
	task wr(input logic [31:0] a, d);
		bus(1'b1, a, d, 32'h0000_0000);
	endtask
	task mv(input int n, input logic d);
		dn <= d;
		st <= 1'b1;
		repeat (n) @(posedge mclk_i);
		st <= 1'b0;
		@(posedge mclk_i);
		cnt = d ? cnt - n[23:0] : cnt + n[23:0];
	endtask
	// flag modes raise the flag first so the index edge sees it settled
	task fire(input int md, sl);
		if (md == 0)
			wr(A_C, 32'h0000_4000);
		else begin
			if (md > 1)
				flg[sl] <= 1'b1;
			repeat (3) @(posedge mclk_i);
			if (md != 2)
				idx <= 1'b1;
			repeat (3) @(posedge mclk_i);
			idx <= 1'b0;
			flg <= 4'h0;
		end
		repeat (4) @(posedge mclk_i);
	endtask
	always @(posedge mclk_i) begin
		if (rdp && hrdy === 1'b1) begin
			e = q.pop_front();
			cmp(hrdata & e[63:32], e[31:0]);
		end
		rdp <= hsel && htrans[1] && !hwrite && hrdy;
		cyc++;
		if (cyc == 20000) begin
			failures++;
			close_out;
		end
	end
	initial begin
		void'($urandom(32'h6adf));
		repeat (8) @(posedge mclk_i);
		rstn_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		rd(A_C, 32'h0002_3800, 32'h0000_0000);
		rd(A_P, 32'h00ff_ffff, 32'h0000_0000);
		rd(32'h0003_0004, 32'hffff_ffff, 32'h0000_0000);
		nn = int'($urandom % 8) + 2;
		c = 24'h00_0000 - nn[23:0];
		wr(A_P, {{8{c[23]}}, c});
		mv(nn, 1'b1);
		repeat (2) @(posedge mclk_i);
		rd(A_C, 32'h0001_0000, 32'h0001_0000);
		mv(1, 1'b1);
		rd(A_C, 32'h0001_0000, 32'h0000_0000);
		iv = int'($urandom % 2);
		wr(A_C, 32'h0000_1800 | (32'(iv) << 13));
		mv(1, 1'b0);
		mv(1, 1'b0);
		rd(A_C, 32'h0001_0000, 32'h0001_0000);
		cmp({31'h0, pin}, 32'(iv ^ 1));
		cmp({31'h0, oe_n}, 32'h0000_0000);
		wr(A_C, 32'h0000_1000);
		wr(A_C, 32'h0000_1800);
		rd(A_C, 32'h0001_0000, 32'h0000_0000);
		wr(A_C, 32'h0000_1000);
		c = cnt + 24'h00_0002;
		wr(A_P, {{8{c[23]}}, c});
		mv(2, 1'b0);
		repeat (2) @(posedge mclk_i);
		cmp({31'h0, pin}, 32'h0000_0001);
		cmp({31'h0, oe_n}, 32'h0000_0000);
		rd(A_C, 32'h0001_0000, 32'h0001_0000);
		for (m = 0; m < 4; m++) begin
			s = int'($urandom % 4);
			wr(A_T, 32'(s * 16 + m));
			mv(int'($urandom % 5) + 1, 1'b0);
			k = cnt;
			fire(m, s);
			rd(A_C, 32'h0002_0000, 32'h0002_0000);
			mv(2, 1'b0);
			fire(m, s);
			rd(A_P, 32'h00ff_ffff, {8'h00, k});
			rd(A_C, 32'h0002_0000, 32'h0000_0000);
		end
		close_out;
	end
endmodule
